// File: core/uart_device_end.sv
`timescale 1ns/100ps
module uart_device_end #(
    parameter int DATA_BITS      = 8,
    parameter int RX_DEPTH       = uart_link_pkg::RX_DEPTH_DEF,
    parameter int POWERUP_CYCLES = uart_link_pkg::POWERUP_CYCLES
) (
    input  wire logic                   sys_clk_in,
    input  wire logic                   reset_n_in,
    input  wire logic                   active_low_shutdown_in,
    uart_link_if.device                 link,
    input  wire logic [uart_link_pkg::DIV_W-1:0] baud_div_in,
    input  wire logic                   parity_en_in,
    input  wire logic                   parity_odd_in,
    input  wire logic [DATA_BITS-1:0]   tx_data_in,
    input  wire logic                   tx_valid_in,
    output logic                        tx_ready_out,
    output logic [DATA_BITS-1:0]        rx_data_out,
    output logic                        rx_valid_out,
    input  wire logic                   rx_ready_in,
    output logic                        rx_error_out,
    output logic                        rx_overrun_out,
    output logic                        powered_up_out
);
    import uart_link_pkg::*;

    localparam int CNT_W = (DATA_BITS > 1) ? $clog2(DATA_BITS) : 1;
    localparam int AW    = $clog2(RX_DEPTH);
    localparam int PWR_W = $clog2(POWERUP_CYCLES + 1);
    localparam logic [AW:0] FULL_FILL = (AW + 1)'(RX_DEPTH);
    localparam logic [AW:0] RTS_FILL  = (AW + 1)'(RX_DEPTH - RX_DEPTH / RTS_DIV);

    typedef struct packed {
        tx_state_type                       ts;
        logic [DIV_W-1:0]                   tcnt;
        logic [CNT_W-1:0]                   tbit;
        logic [DATA_BITS-1:0]               tsh;
        logic                               tpar;
        logic                               txd;
        logic                               pend_v;
        logic [DATA_BITS-1:0]               pend;
        logic                               tx_rdy;
        rx_state_type                       rs;
        logic [DIV_W-1:0]                   rcnt;
        logic [CNT_W-1:0]                   rbit;
        logic [DATA_BITS-1:0]               rsh;
        logic                               rpar;
        logic [RX_DEPTH-1:0][DATA_BITS-1:0] mem;
        logic [AW-1:0]                      wp;
        logic [AW-1:0]                      rp;
        logic [AW:0]                        fill;
        logic [DATA_BITS-1:0]               odata;
        logic                               ovalid;
        logic                               rerr;
        logic                               rovr;
        logic                               rts;
        logic [PWR_W-1:0]                   pwr;
        logic                               up;
    } dev_state_type;

    dev_state_type    s_d;
    dev_state_type    s_q;
    logic [DIV_W-1:0] div;
    logic             push;
    logic             pop;

    always_comb begin
        // Out-of-range divisors clamp to supported rates
        div = (baud_div_in < DIV_MIN) ? DIV_MIN :
              (baud_div_in > DIV_MAX) ? DIV_MAX : baud_div_in;
        push = 1'b0;
        s_d = s_q;
        s_d.rerr = 1'b0;
        s_d.rovr = 1'b0;
        if (!s_q.up) begin
            if (s_q.pwr == PWR_W'(POWERUP_CYCLES - 1)) begin
                s_d.up = 1'b1;
            end else begin
                s_d.pwr = s_q.pwr + 1'b1;
            end
        end
        if (s_q.tx_rdy && tx_valid_in) begin
            s_d.pend = tx_data_in;
            s_d.pend_v = 1'b1;
        end
        case (s_q.ts)
            TX_IDLE: begin
                s_d.txd = LINE_IDLE;
                // Flow flag checked only between frames: a frame in flight completes
                if (s_q.pend_v && !link.host_cts) begin
                    s_d.ts = TX_START;
                    s_d.tsh = s_d.pend;
                    s_d.pend_v = 1'b0;
                    s_d.tpar = parity_odd_in;
                    s_d.txd = START_LEVEL;
                    s_d.tcnt = div - 1'b1;
                end
            end
            default: begin
                if (s_q.tcnt != '0) begin
                    s_d.tcnt = s_q.tcnt - 1'b1;
                end else begin
                    s_d.tcnt = div - 1'b1;
                    if (s_q.ts == TX_START || (s_q.ts == TX_DATA && s_q.tbit != '0)) begin
                        s_d.ts = TX_DATA;
                        s_d.txd = s_q.tsh[0];
                        s_d.tpar = s_q.tpar ^ s_q.tsh[0];
                        s_d.tsh = s_q.tsh >> 1;
                        s_d.tbit = (s_q.ts == TX_START) ? CNT_W'(DATA_BITS - 1)
                                                        : s_q.tbit - 1'b1;
                    end else if (s_q.ts == TX_DATA && parity_en_in) begin
                        s_d.ts = TX_PARITY;
                        s_d.txd = s_q.tpar;
                    end else if (s_q.ts != TX_STOP) begin
                        s_d.ts = TX_STOP;
                        s_d.txd = STOP_LEVEL;
                    end else begin
                        s_d.ts = TX_IDLE;
                    end
                end
            end
        endcase
        case (s_q.rs)
            RX_IDLE: begin
                if (link.host_to_dev_data == START_LEVEL) begin
                    s_d.rs = RX_START;
                    s_d.rcnt = div >> 1;
                end
            end
            RX_START: begin
                if (s_q.rcnt != '0) begin
                    s_d.rcnt = s_q.rcnt - 1'b1;
                end else if (link.host_to_dev_data == START_LEVEL) begin
                    // Every frame re-aligns on its own start edge and samples mid-bit
                    s_d.rs = RX_DATA;
                    s_d.rcnt = div - 1'b1;
                    s_d.rbit = CNT_W'(DATA_BITS - 1);
                    s_d.rpar = parity_odd_in;
                end else begin
                    s_d.rs = RX_IDLE;
                end
            end
            RX_DATA: begin
                if (s_q.rcnt != '0) begin
                    s_d.rcnt = s_q.rcnt - 1'b1;
                end else begin
                    s_d.rsh = {link.host_to_dev_data, s_q.rsh[DATA_BITS-1:1]};
                    s_d.rpar = s_q.rpar ^ link.host_to_dev_data;
                    s_d.rcnt = div - 1'b1;
                    s_d.rbit = s_q.rbit - 1'b1;
                    if (s_q.rbit == '0) begin
                        s_d.rs = parity_en_in ? RX_PARITY : RX_STOP;
                    end
                end
            end
            RX_PARITY: begin
                if (s_q.rcnt != '0) begin
                    s_d.rcnt = s_q.rcnt - 1'b1;
                end else begin
                    s_d.rpar = s_q.rpar ^ link.host_to_dev_data;
                    s_d.rcnt = div - 1'b1;
                    s_d.rs = RX_STOP;
                end
            end
            RX_STOP: begin
                if (s_q.rcnt != '0) begin
                    s_d.rcnt = s_q.rcnt - 1'b1;
                end else begin
                    // Leaving at mid stop bit tolerates a sender running fast
                    s_d.rs = RX_IDLE;
                    s_d.rerr = (link.host_to_dev_data != STOP_LEVEL)
                             || (parity_en_in && s_q.rpar);
                    push = 1'b1;
                end
            end
            default: begin
                s_d.rs = RX_IDLE;
            end
        endcase
        pop = (s_q.fill != '0) && (!s_q.ovalid || rx_ready_in);
        if (pop) begin
            s_d.odata = s_q.mem[s_q.rp];
            s_d.ovalid = 1'b1;
            s_d.rp = s_q.rp + 1'b1;
        end else if (rx_ready_in) begin
            s_d.ovalid = 1'b0;
        end
        // A full buffer drops and flags the byte rather than stall the line
        if (push && s_q.fill == FULL_FILL) begin
            push = 1'b0;
            s_d.rovr = 1'b1;
        end
        if (push) begin
            s_d.mem[s_q.wp] = s_q.rsh;
            s_d.wp = s_q.wp + 1'b1;
        end
        if (push && !pop) begin
            s_d.fill = s_q.fill + 1'b1;
        end else if (pop && !push) begin
            s_d.fill = s_q.fill - 1'b1;
        end
        // Depth/4 room left covers the host's in-flight bytes
        s_d.rts = !s_d.up || (s_d.fill >= RTS_FILL);
        s_d.tx_rdy = s_d.up && !s_d.pend_v;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in || !active_low_shutdown_in) begin
            s_q <= '0;
            s_q.txd <= LINE_IDLE;
            s_q.rts <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.dev_to_host_data = s_q.txd;
    assign link.dev_rts          = s_q.rts;
    assign tx_ready_out          = s_q.tx_rdy;
    assign rx_data_out           = s_q.odata;
    assign rx_valid_out          = s_q.ovalid;
    assign rx_error_out          = s_q.rerr;
    assign rx_overrun_out        = s_q.rovr;
    assign powered_up_out        = s_q.up;

endmodule : uart_device_end

// File: core/uart_host_end.sv
`timescale 1ns/100ps
module uart_host_end #(
    parameter int DATA_BITS = 8
) (
    input  wire logic                   sys_clk_in,
    input  wire logic                   reset_n_in,
    uart_link_if.host                   link,
    input  wire logic [uart_link_pkg::DIV_W-1:0] baud_div_in,
    input  wire logic                   parity_en_in,
    input  wire logic                   parity_odd_in,
    input  wire logic [DATA_BITS-1:0]   tx_data_in,
    input  wire logic                   tx_valid_in,
    output logic                        tx_ready_out,
    output logic [DATA_BITS-1:0]        rx_data_out,
    output logic                        rx_valid_out,
    output logic                        rx_error_out,
    input  wire logic                   rx_hold_in
);
    import uart_link_pkg::*;

    localparam int CNT_W = (DATA_BITS > 1) ? $clog2(DATA_BITS) : 1;

    typedef struct packed {
        tx_state_type           ts;
        logic [DIV_W-1:0]       tcnt;
        logic [CNT_W-1:0]       tbit;
        logic [DATA_BITS-1:0]   tsh;
        logic                   tpar;
        logic                   txd;
        logic                   pend_v;
        logic [DATA_BITS-1:0]   pend;
        logic                   tx_rdy;
        rx_state_type           rs;
        logic [DIV_W-1:0]       rcnt;
        logic [CNT_W-1:0]       rbit;
        logic [DATA_BITS-1:0]   rsh;
        logic                   rpar;
        logic [DATA_BITS-1:0]   rdata;
        logic                   rvalid;
        logic                   rerr;
        logic                   cts;
    } host_state_type;

    host_state_type   s_q;
    host_state_type   s_d;
    logic [DIV_W-1:0] div;

    always_comb begin
        div = (baud_div_in < DIV_MIN) ? DIV_MIN :
              (baud_div_in > DIV_MAX) ? DIV_MAX : baud_div_in;
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.rerr = 1'b0;
        s_d.cts = rx_hold_in;
        if (s_q.tx_rdy && tx_valid_in) begin
            s_d.pend = tx_data_in;
            s_d.pend_v = 1'b1;
        end
        case (s_q.ts)
            TX_IDLE: begin
                s_d.txd = LINE_IDLE;
                // Checked between frames only, so a raised flag stops us in one byte
                if (s_q.pend_v && !link.dev_rts) begin
                    s_d.ts = TX_START;
                    s_d.tsh = s_d.pend;
                    s_d.pend_v = 1'b0;
                    s_d.tpar = parity_odd_in;
                    s_d.txd = START_LEVEL;
                    s_d.tcnt = div - 1'b1;
                end
            end
            default: begin
                if (s_q.tcnt != '0) begin
                    s_d.tcnt = s_q.tcnt - 1'b1;
                end else begin
                    s_d.tcnt = div - 1'b1;
                    if (s_q.ts == TX_START || (s_q.ts == TX_DATA && s_q.tbit != '0)) begin
                        s_d.ts = TX_DATA;
                        s_d.txd = s_q.tsh[0];
                        s_d.tpar = s_q.tpar ^ s_q.tsh[0];
                        s_d.tsh = s_q.tsh >> 1;
                        s_d.tbit = (s_q.ts == TX_START) ? CNT_W'(DATA_BITS - 1)
                                                        : s_q.tbit - 1'b1;
                    end else if (s_q.ts == TX_DATA && parity_en_in) begin
                        s_d.ts = TX_PARITY;
                        s_d.txd = s_q.tpar;
                    end else if (s_q.ts != TX_STOP) begin
                        s_d.ts = TX_STOP;
                        s_d.txd = STOP_LEVEL;
                    end else begin
                        s_d.ts = TX_IDLE;
                    end
                end
            end
        endcase
        case (s_q.rs)
            RX_IDLE: begin
                if (link.dev_to_host_data == START_LEVEL) begin
                    s_d.rs = RX_START;
                    s_d.rcnt = div >> 1;
                end
            end
            RX_START: begin
                if (s_q.rcnt != '0) begin
                    s_d.rcnt = s_q.rcnt - 1'b1;
                end else if (link.dev_to_host_data == START_LEVEL) begin
                    // Mid-bit sampling keeps margin for per-bit jitter
                    s_d.rs = RX_DATA;
                    s_d.rcnt = div - 1'b1;
                    s_d.rbit = CNT_W'(DATA_BITS - 1);
                    s_d.rpar = parity_odd_in;
                end else begin
                    s_d.rs = RX_IDLE;
                end
            end
            RX_DATA: begin
                if (s_q.rcnt != '0) begin
                    s_d.rcnt = s_q.rcnt - 1'b1;
                end else begin
                    s_d.rsh = {link.dev_to_host_data, s_q.rsh[DATA_BITS-1:1]};
                    s_d.rpar = s_q.rpar ^ link.dev_to_host_data;
                    s_d.rcnt = div - 1'b1;
                    s_d.rbit = s_q.rbit - 1'b1;
                    if (s_q.rbit == '0) begin
                        s_d.rs = parity_en_in ? RX_PARITY : RX_STOP;
                    end
                end
            end
            RX_PARITY: begin
                if (s_q.rcnt != '0) begin
                    s_d.rcnt = s_q.rcnt - 1'b1;
                end else begin
                    s_d.rpar = s_q.rpar ^ link.dev_to_host_data;
                    s_d.rcnt = div - 1'b1;
                    s_d.rs = RX_STOP;
                end
            end
            RX_STOP: begin
                if (s_q.rcnt != '0) begin
                    s_d.rcnt = s_q.rcnt - 1'b1;
                end else begin
                    // Idle again at mid stop bit, so a fast sender is caught
                    s_d.rs = RX_IDLE;
                    s_d.rdata = s_q.rsh;
                    s_d.rvalid = 1'b1;
                    s_d.rerr = (link.dev_to_host_data != STOP_LEVEL)
                             || (parity_en_in && s_q.rpar);
                end
            end
            default: begin
                s_d.rs = RX_IDLE;
            end
        endcase
        s_d.tx_rdy = !s_d.pend_v;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            s_q <= '0;
            s_q.txd <= LINE_IDLE;
            s_q.cts <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.host_to_dev_data = s_q.txd;
    assign link.host_cts         = s_q.cts;
    assign tx_ready_out          = s_q.tx_rdy;
    assign rx_data_out           = s_q.rdata;
    assign rx_valid_out          = s_q.rvalid;
    assign rx_error_out          = s_q.rerr;

endmodule : uart_host_end

// File: core/uart_link_if.sv
`timescale 1ns/100ps
interface uart_link_if;
    logic dev_to_host_data;
    logic host_to_dev_data;
    logic dev_rts;
    logic host_cts;

    modport device (
        output dev_to_host_data,
        output dev_rts,
        input  host_to_dev_data,
        input  host_cts
    );

    modport host (
        input  dev_to_host_data,
        input  dev_rts,
        output host_to_dev_data,
        output host_cts
    );
endinterface : uart_link_if

// File: core/uart_link_pkg.sv
package uart_link_pkg;

    localparam int CLK_HZ        = 50_000_000;
    localparam int DIV_W         = 16;

    // Supported bit rates, in bits per second
    localparam int BAUD_MIN_BPS  = 37_500;
    localparam int BAUD_MAX_BPS  = 4_000_000;
    localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / BAUD_MIN_BPS);
    localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(CLK_HZ / BAUD_MAX_BPS);

    // Power-up indication limit
    localparam int POWERUP_MS     = 100;
    localparam int POWERUP_CYCLES = (CLK_HZ / 1000) * POWERUP_MS;

    // Request-to-send rises when free room falls to depth/RTS_DIV
    localparam int RX_DEPTH_DEF  = 64;
    localparam int RTS_DIV       = 4;

    // Line levels
    localparam logic LINE_IDLE   = 1'b1;
    localparam logic START_LEVEL = 1'b0;
    localparam logic STOP_LEVEL  = 1'b1;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_PARITY,
        TX_STOP
    } tx_state_type;

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_PARITY,
        RX_STOP
    } rx_state_type;

endpackage : uart_link_pkg

// File: verification/host_uart_flow_control_assertions.sv
`timescale 1ns/100ps
module host_uart_flow_control_assertions #(
    parameter int DIV            = 12,
    parameter int POWERUP_CYCLES = 20
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic dev_to_host_data,
    input wire logic host_to_dev_data,
    input wire logic dev_rts,
    input wire logic host_cts
);
    localparam int FRAME = 10 * DIV;
    // Falls inside a frame are data bits, not starts
    logic        d2h_prev_q;
    logic        h2d_prev_q;
    logic [11:0] d2h_win_q;
    logic [11:0] h2d_win_q;
    logic [23:0] boot_q;
    logic        booting_q;
    wire d2h_start = d2h_prev_q && !dev_to_host_data && !d2h_win_q;
    wire h2d_start = h2d_prev_q && !host_to_dev_data && !h2d_win_q;

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            d2h_prev_q <= 1'b1;
            h2d_prev_q <= 1'b1;
            d2h_win_q  <= 12'h000;
            h2d_win_q  <= 12'h000;
            boot_q     <= 24'h000000;
            booting_q  <= 1'b1;
        end else begin
            d2h_prev_q <= dev_to_host_data;
            h2d_prev_q <= host_to_dev_data;
            d2h_win_q  <= d2h_start ? 12'(FRAME - 1) : d2h_win_q - 12'(|d2h_win_q);
            h2d_win_q  <= h2d_start ? 12'(FRAME - 1) : h2d_win_q - 12'(|h2d_win_q);
            boot_q     <= boot_q + 24'(booting_q);
            booting_q  <= booting_q && dev_rts;
        end
    end

    a_reset_rts_high: assert property (
        @(posedge sys_clk_in) !reset_n_in |=> dev_rts) else $error("rts low after reset");
    a_reset_lines_idle: assert property (
        @(posedge sys_clk_in) !reset_n_in |=> dev_to_host_data && host_to_dev_data)
        else $error("line busy after reset");
    a_boot_rts_held: assert property (
        @(posedge sys_clk_in) disable iff (!reset_n_in) $rose(reset_n_in) |-> dev_rts [*8])
        else $error("rts dropped before power-up");
    a_boot_rts_bound: assert property (
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        booting_q |-> boot_q <= 24'(POWERUP_CYCLES + 4)) else $error("rts late after power-up");
    a_cts_gates_tx: assert property (
        @(posedge sys_clk_in) disable iff (!reset_n_in) d2h_start |-> !$past(host_cts))
        else $error("device sent under cts");
    a_rts_gates_host: assert property (
        @(posedge sys_clk_in) disable iff (!reset_n_in) h2d_start |-> !$past(dev_rts))
        else $error("host sent under rts");
    a_d2h_start_bit: assert property (
        @(posedge sys_clk_in) disable iff (!reset_n_in) d2h_start |-> !dev_to_host_data [*8])
        else $error("device start too short");
    a_h2d_start_bit: assert property (
        @(posedge sys_clk_in) disable iff (!reset_n_in) h2d_start |-> !host_to_dev_data [*8])
        else $error("host start too short");
endmodule : host_uart_flow_control_assertions

// File: verification/host_uart_flow_control_bench.sv
`timescale 1ns/100ps
module host_uart_flow_control_bench;
    import uart_link_pkg::*;
    localparam int DIV   = 12;
    localparam int DEPTH = 8;
    localparam int PWR   = 20;
    localparam int THR   = DEPTH - DEPTH / RTS_DIV;
    logic             sys_clk_in = 1'b0;
    logic             reset_n_in = 1'b0;
    logic             active_low_shutdown = 1'b1;
    logic [DIV_W-1:0] baud_div = DIV_W'(DIV);
    logic             par_en = 1'b0;
    logic             par_odd = 1'b0;
    logic [7:0]       dev_tx_data = 8'h00;
    logic [7:0]       host_tx_data = 8'h00;
    logic             dev_tx_valid = 1'b0;
    logic             host_tx_valid = 1'b0;
    logic             dev_rx_ready = 1'b1;
    logic             rx_hold = 1'b0;
    logic             dev_tx_ready, host_tx_ready, dev_rx_valid, host_rx_valid;
    logic             dev_rx_error, host_rx_error, dev_overrun, powered_up;
    logic [7:0]       dev_rx_data, host_rx_data, dev_q[$], host_q[$];
    int               bad_count = 0;
    int               tests_run = 0;
    int               err_seen = 0;

    always #10 sys_clk_in = ~sys_clk_in;

    uart_link_if link_bus ();
    uart_device_end #(.DATA_BITS(8), .RX_DEPTH(DEPTH), .POWERUP_CYCLES(PWR)) uart_device_end_inst (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .active_low_shutdown_in(active_low_shutdown), .link(link_bus.device),
        .baud_div_in(baud_div), .parity_en_in(par_en), .parity_odd_in(par_odd),
        .tx_data_in(dev_tx_data), .tx_valid_in(dev_tx_valid), .tx_ready_out(dev_tx_ready),
        .rx_data_out(dev_rx_data), .rx_valid_out(dev_rx_valid), .rx_ready_in(dev_rx_ready),
        .rx_error_out(dev_rx_error), .rx_overrun_out(dev_overrun), .powered_up_out(powered_up));
    uart_host_end #(.DATA_BITS(8)) uart_host_end_inst (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .link(link_bus.host),
        .baud_div_in(baud_div), .parity_en_in(par_en), .parity_odd_in(par_odd),
        .tx_data_in(host_tx_data), .tx_valid_in(host_tx_valid), .tx_ready_out(host_tx_ready),
        .rx_data_out(host_rx_data), .rx_valid_out(host_rx_valid),
        .rx_error_out(host_rx_error), .rx_hold_in(rx_hold));
    host_uart_flow_control_assertions #(.DIV(DIV), .POWERUP_CYCLES(PWR)) checker_inst (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .dev_to_host_data(link_bus.dev_to_host_data), .host_to_dev_data(link_bus.host_to_dev_data),
        .dev_rts(link_bus.dev_rts), .host_cts(link_bus.host_cts));

    always @(posedge sys_clk_in) begin
        if ((dev_rx_valid & dev_rx_ready) === 1'b1) dev_q.push_back(dev_rx_data);
        if (host_rx_valid === 1'b1) host_q.push_back(host_rx_data);
        if ((dev_rx_error | host_rx_error | dev_overrun) === 1'b1) err_seen++;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    task automatic give_up();
        bad_count++;
        $display("Error at %0t: wait ran out", $time);
        finish_test();
    endtask : give_up

    // Valid and data hold until ready is seen high
    task automatic send_byte(input bit from_dev, input logic [7:0] b);
        int n;
        n = 0;
        @(negedge sys_clk_in);
        if (from_dev) begin
            dev_tx_data  = b;
            dev_tx_valid = 1'b1;
        end else begin
            host_tx_data  = b;
            host_tx_valid = 1'b1;
        end
        while ((from_dev ? dev_tx_ready : host_tx_ready) !== 1'b1) begin
            @(negedge sys_clk_in);
            n++;
            if (n > 4000) give_up();
        end
        @(negedge sys_clk_in);
        dev_tx_valid  = 1'b0;
        host_tx_valid = 1'b0;
    endtask : send_byte

    task automatic wait_q(input bit on_dev, input int count);
        int n;
        n = 0;
        while ((on_dev ? dev_q.size() : host_q.size()) < count) begin
            @(negedge sys_clk_in);
            n++;
            if (n > 20000) give_up();
        end
    endtask : wait_q

    task automatic wait_line_low(output int n);
        n = 0;
        while (link_bus.dev_to_host_data !== START_LEVEL) begin
            @(negedge sys_clk_in);
            n++;
            if (n > 4000) give_up();
        end
    endtask : wait_line_low

    task automatic watch_line(input logic [7:0] b);
        int         n;
        logic [10:0] bits;
        bits = par_en ? {STOP_LEVEL, (^b) ^ par_odd, b, START_LEVEL} : {2'b11, b, START_LEVEL};
        wait_line_low(n);
        repeat (DIV / 2) @(negedge sys_clk_in);
        for (int i = 0; i < (par_en ? 11 : 10); i++) begin
            check(16'(link_bus.dev_to_host_data), 16'(bits[i]));
            repeat (DIV) @(negedge sys_clk_in);
        end
        check(16'(link_bus.dev_to_host_data), 16'(LINE_IDLE));
    endtask : watch_line

    task automatic t_power_up();
        int n;
        for (int pass = 0; pass < 2; pass++) begin
            if (pass == 1) begin
                active_low_shutdown = 1'b0;
                repeat (3) @(negedge sys_clk_in);
                check({14'h0000, link_bus.dev_rts, powered_up}, 16'h0002);
                active_low_shutdown = 1'b1;
            end
            n = 0;
            while (link_bus.dev_rts !== 1'b0) begin
                @(negedge sys_clk_in);
                n++;
                if (n > PWR + 10) give_up();
            end
            check(16'(n >= PWR - 1 && n <= PWR + 2), 16'h0001);
            check(16'(powered_up), 16'h0001);
        end
        $display("Test power_up done");
    endtask : t_power_up

    task automatic t_dev_to_host();
        logic [7:0] bytes [3] = '{8'hA5, 8'h3C, 8'h81};
        for (int m = 0; m < 3; m++) begin
            par_en  = (m != 0);
            par_odd = (m == 2);
            fork
                send_byte(1'b1, bytes[m]);
                watch_line(bytes[m]);
            join
            wait_q(1'b0, 1);
            check(16'(host_q.pop_front()), 16'(bytes[m]));
        end
        $display("Test dev_to_host done");
    endtask : t_dev_to_host

    task automatic t_host_to_dev();
        logic [7:0] bytes [3] = '{8'h00, 8'hFF, 8'h5A};
        par_en  = 1'b1;
        par_odd = 1'b1;
        for (int i = 0; i < 3; i++) send_byte(1'b0, bytes[i]);
        wait_q(1'b1, 3);
        for (int i = 0; i < 3; i++) check(16'(dev_q.pop_front()), 16'(bytes[i]));
        par_en = 1'b0;
        $display("Test host_to_dev done");
    endtask : t_host_to_dev

    task automatic t_cts_halt();
        int n;
        rx_hold = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        send_byte(1'b1, 8'h96);
        repeat (15 * DIV) @(negedge sys_clk_in);
        check(16'(link_bus.dev_to_host_data), 16'h0001);
        check(16'(host_q.size()), 16'h0000);
        rx_hold = 1'b0;
        wait_line_low(n);
        check(16'(n <= 5), 16'h0001);
        wait_q(1'b0, 1);
        check(16'(host_q.pop_front()), 16'h0096);
        $display("Test cts_halt done");
    endtask : t_cts_halt

    task automatic t_rts_fill();
        dev_rx_ready = 1'b0;
        for (int i = 0; i <= THR; i++) begin
            send_byte(1'b0, 8'(8'h10 + i));
            repeat (12 * DIV) @(negedge sys_clk_in);
            check(16'(link_bus.dev_rts), 16'(i >= THR));
        end
        send_byte(1'b0, 8'(8'h10 + THR + 1));
        repeat (36 * DIV) @(negedge sys_clk_in);
        check({14'h0000, host_tx_ready, link_bus.host_to_dev_data}, 16'h0001);
        dev_rx_ready = 1'b1;
        wait_q(1'b1, THR + 2);
        for (int i = 0; i <= THR + 1; i++) begin
            check(16'(dev_q.pop_front()), 16'(8'h10 + i));
        end
        repeat (4) @(negedge sys_clk_in);
        check(16'(link_bus.dev_rts), 16'h0000);
        $display("Test rts_fill done");
    endtask : t_rts_fill

    initial begin
        repeat (6) @(negedge sys_clk_in);
        reset_n_in = 1'b1;
        t_power_up();
        t_dev_to_host();
        t_host_to_dev();
        t_cts_halt();
        t_rts_fill();
        check(16'(err_seen), 16'h0000);
        finish_test();
    end
endmodule : host_uart_flow_control_bench
